// ==== design/byte_port.sv ====
module byte_port (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic mode,
    input wire logic strobe,
    input wire logic select_first,
    input wire logic select_second,
    input wire logic clear_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic service_request_n
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    byte_port_pkg::ctrl_pins_t raw_w;
    byte_port_pkg::ctrl_pins_t pin_w;
    logic [7:0] d1_r;
    logic [7:0] d2_r;
    logic [7:0] d3_r;
    logic [7:0] din_r;

    assign raw_w = '{strobe: strobe, select_first: select_first, select_second: select_second,
                     clear_n: clear_n, mode: mode};

    pin_sync #(.W(5)) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in(raw_w),
        .pin_level(pin_w)
    );

    // Data runs through the same depth so it lines up with the strobe
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            d1_r <= byte_port_pkg::DATA_RST;
            d2_r <= byte_port_pkg::DATA_RST;
            d3_r <= byte_port_pkg::DATA_RST;
            din_r <= byte_port_pkg::DATA_RST;
        end
        else
        begin
            d1_r <= data_in;
            d2_r <= d1_r;
            d3_r <= d2_r;
            if (d2_r == d3_r)
            begin
                din_r <= d3_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic strobe_d_r;
    logic sel_d_r;

    // Falling edge of a level seen one cycle apart
    function automatic logic fell_edge(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : fell_edge

    wire sel_w = pin_w.select_first & pin_w.select_second;
    wire out_mode_w = pin_w.mode == byte_port_pkg::MODE_OUTPUT;
    wire strobe_fall_w = fell_edge(strobe_d_r, pin_w.strobe);
    // Edge polarity is a detail of the detector only
    wire sel_end_w = fell_edge(sel_d_r, sel_w);
    wire transp_w = out_mode_w ? (sel_w & pin_w.strobe) : pin_w.strobe;

    logic [7:0] reg_r;
    logic [7:0] reg_nxt;
    logic sr_n_r;
    logic sr_n_nxt;

    always_comb
    begin
        reg_nxt = reg_r;
        if (!pin_w.clear_n)
        begin
            reg_nxt = byte_port_pkg::DATA_RST;
        end
        if (transp_w)
        begin
            reg_nxt = din_r;
        end
    end

    always_comb
    begin
        sr_n_nxt = sr_n_r;
        if (!out_mode_w)
        begin
            if (sel_end_w || !pin_w.clear_n)
            begin
                sr_n_nxt = 1'b1;
            end
            if (strobe_fall_w)
            begin
                sr_n_nxt = 1'b0;
            end
        end
        else
        begin
            if (strobe_fall_w || !pin_w.clear_n)
            begin
                sr_n_nxt = 1'b1;
            end
            // Glitchy selects would land here falsely
            if (sel_end_w && pin_w.clear_n)
            begin
                sr_n_nxt = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            strobe_d_r <= byte_port_pkg::SYNC_RST;
            sel_d_r <= byte_port_pkg::SYNC_RST;
            reg_r <= byte_port_pkg::DATA_RST;
            sr_n_r <= byte_port_pkg::REQ_IDLE_N;
        end
        else
        begin
            strobe_d_r <= pin_w.strobe;
            sel_d_r <= sel_w;
            reg_r <= reg_nxt;
            sr_n_r <= sr_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out = reg_r;
    assign data_oe = out_mode_w | sel_w;
    assign service_request_n = sr_n_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_input_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
        !out_mode_w |-> (data_oe == sel_w)) else $error("input oe wrong");
    a_output_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
        out_mode_w |-> data_oe) else $error("output oe low");
    a_in_latch_req: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!out_mode_w && strobe_fall_w) |=> !service_request_n) else $error("no request");
    a_in_sel_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!out_mode_w && sel_end_w && !strobe_fall_w) |=> service_request_n) else $error("no reset");
    a_out_sel_req: assert property (@(posedge sys_clk) disable iff (!rstn)
        (out_mode_w && sel_end_w && pin_w.clear_n) |=> !service_request_n) else $error("no out req");
    a_out_strobe_end: assert property (@(posedge sys_clk) disable iff (!rstn)
        (out_mode_w && strobe_fall_w && !sel_end_w) |=> service_request_n) else $error("req stuck");
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!pin_w.clear_n && !transp_w) |=> (data_out == 8'h00)) else $error("clear failed");
    a_transp_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
        transp_w |=> (data_out == $past(din_r))) else $error("not transparent");
    a_hold_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
        (pin_w.clear_n && !transp_w) |=> $stable(data_out)) else $error("latch moved");
    a_out_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        (out_mode_w && !sel_w && pin_w.clear_n) |=> $stable(data_out)) else $error("ungated");

    // ------------------------------------------------------------
    // Request and latch sequences
    // ------------------------------------------------------------
    sequence s_in_req_set;
        !out_mode_w && strobe_fall_w;
    endsequence

    sequence s_in_req_keep;
        !out_mode_w && !sel_end_w && pin_w.clear_n;
    endsequence

    sequence s_out_req_set;
        out_mode_w && sel_end_w && pin_w.clear_n;
    endsequence

    sequence s_out_req_keep;
        out_mode_w && !strobe_fall_w && pin_w.clear_n;
    endsequence

    sequence s_in_open;
        !out_mode_w && pin_w.strobe;
    endsequence

    sequence s_in_shut;
        !out_mode_w && strobe_fall_w && pin_w.clear_n;
    endsequence

    sequence s_out_shut;
        out_mode_w && !transp_w && pin_w.clear_n;
    endsequence

    // ------------------------------------------------------------
    // Sequenced checks
    // ------------------------------------------------------------
    // A request must survive until its own cancelling event
    a_in_req_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_in_req_set ##1 s_in_req_keep |=> !service_request_n) else $error("in request dropped");
    a_out_req_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_out_req_set ##1 s_out_req_keep |=> !service_request_n) else $error("out request dropped");
    a_in_latch_value: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_in_open ##1 s_in_shut |=> (data_out == $past(din_r, 2))) else $error("in latch lost");
    a_out_latch_value: assert property (@(posedge sys_clk) disable iff (!rstn)
        (out_mode_w && transp_w) ##1 s_out_shut |=> (data_out == $past(din_r, 2))) else $error("out latch lost");
    a_req_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!strobe_fall_w && !sel_end_w && pin_w.clear_n) |=> $stable(service_request_n)) else $error("request moved");
    a_in_clear_req: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!out_mode_w && !pin_w.clear_n && !strobe_fall_w) |=> service_request_n) else $error("in clear missed");
    a_out_clear_req: assert property (@(posedge sys_clk) disable iff (!rstn)
        (out_mode_w && !pin_w.clear_n) |=> service_request_n) else $error("out clear missed");
    a_in_oe_off: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!out_mode_w && !sel_w) |-> !data_oe) else $error("input drives unselected");

    // Runs without the disable so the idle levels are seen
    a_reset_idle: assert property (@(posedge sys_clk)
        !rstn |=> (service_request_n && (data_out == byte_port_pkg::DATA_RST) && !data_oe)) else $error("reset not idle");
endmodule : byte_port

// ==== design/byte_port_pkg.sv ====
package byte_port_pkg;
    localparam int DATA_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam int SYNC_STAGES = 3;
    localparam logic SYNC_RST = 1'b0;
    localparam logic REQ_IDLE_N = 1'b1;

    typedef enum logic [0:0]
    {
        MODE_INPUT = 1'b0,
        MODE_OUTPUT = 1'b1
    } port_mode_t;

    typedef struct packed
    {
        logic strobe;
        logic select_first;
        logic select_second;
        logic clear_n;
        logic mode;
    } ctrl_pins_t;
endpackage : byte_port_pkg

// ==== design/pin_sync.sv ====
module pin_sync #(
    parameter int W = 5
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Change counts only once the last two stages agree
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_level <= '0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++)
            begin
                if (s2_r[i] == s3_r[i])
                begin
                    pin_level[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : pin_sync

// ==== sim/bus_peer.sv ====
// ----------------------------------------
// Processor bus and peripheral side
// ----------------------------------------
module bus_peer (
    input wire logic sys_clk,
    output byte_port_pkg::ctrl_pins_t pins,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        pins = 5'h02;
        data_in = 8'h00;
    end

    // Every level is held for 9 cycles, so no select pulse is transient
    task automatic drive(input byte_port_pkg::ctrl_pins_t p, input logic [7:0] d);
        @(posedge sys_clk);
        pins <= p;
        data_in <= d;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : drive
endmodule : bus_peer

// ==== sim/mode_programmable_byte_io_port_tb_top.sv ====
module mode_programmable_byte_io_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] data_out;
    logic data_oe;
    logic service_request_n;
    int n_mismatch = 0;
    int checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    byte_port_pkg::ctrl_pins_t peer_pins;
    logic [7:0] peer_data;

    bus_peer peer (
        .sys_clk(sys_clk),
        .pins(peer_pins),
        .data_in(peer_data)
    );

    // Pin codes: strobe, select_first, select_second, clear_n, mode
    byte_port dut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .mode(peer_pins.mode),
        .strobe(peer_pins.strobe),
        .select_first(peer_pins.select_first),
        .select_second(peer_pins.select_second),
        .clear_n(peer_pins.clear_n),
        .data_in(peer_data),
        .data_out(data_out),
        .data_oe(data_oe),
        .service_request_n(service_request_n)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic test_input();
        peer.drive(5'h12, 8'hA5);
        check(data_out, 8'hA5);
        peer.drive(5'h02, 8'hA5);
        peer.drive(5'h02, 8'h5A);
        check({7'h00, service_request_n}, 8'h00);
        check(data_out, 8'hA5);
        check({7'h00, data_oe}, 8'h00);
        peer.drive(5'h0E, 8'h5A);
        check({7'h00, data_oe}, 8'h01);
        check(data_out, 8'hA5);
        peer.drive(5'h02, 8'h5A);
        check({7'h00, service_request_n}, 8'h01);
        $display("test_input done");
    endtask : test_input

    task automatic test_output();
        peer.drive(5'h03, 8'h5A);
        check({7'h00, data_oe}, 8'h01);
        peer.drive(5'h13, 8'hC3);
        check(data_out, 8'hA5);
        peer.drive(5'h03, 8'h3C);
        peer.drive(5'h0F, 8'h3C);
        peer.drive(5'h1F, 8'h3C);
        check(data_out, 8'h3C);
        peer.drive(5'h0F, 8'h3C);
        peer.drive(5'h03, 8'h3C);
        check({7'h00, service_request_n}, 8'h00);
        check({7'h00, data_oe}, 8'h01);
        peer.drive(5'h13, 8'h3C);
        check({7'h00, service_request_n}, 8'h00);
        peer.drive(5'h03, 8'h3C);
        check({7'h00, service_request_n}, 8'h01);
        $display("test_output done");
    endtask : test_output

    task automatic test_clear();
        peer.drive(5'h0F, 8'h3C);
        peer.drive(5'h03, 8'h3C);
        peer.drive(5'h01, 8'h3C);
        check(data_out, 8'h00);
        check({7'h00, service_request_n}, 8'h01);
        peer.drive(5'h00, 8'h3C);
        check({7'h00, data_oe}, 8'h00);
        check(data_out, 8'h00);
        peer.drive(5'h10, 8'h3C);
        check(data_out, 8'h3C);
        peer.drive(5'h12, 8'h3C);
        peer.drive(5'h02, 8'h3C);
        check({7'h00, service_request_n}, 8'h00);
        check(data_out, 8'h3C);
        peer.drive(5'h00, 8'h3C);
        check({7'h00, service_request_n}, 8'h01);
        check(data_out, 8'h00);
        $display("test_clear done");
    endtask : test_clear

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        peer.drive(5'h02, 8'h00);
        test_input();
        test_output();
        test_clear();
        complete_run();
    end

    // Tests need about 210 cycles
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        n_mismatch++;
        complete_run();
    end
endmodule : mode_programmable_byte_io_port_tb_top
